// *** rtl/rxc_top.sv ***
`timescale 1ns/1ns
module rxc_top
   import rxc_pkg::*;
(
   input  wire logic        aclk,            // bus clock, 25 mhz
   input  wire logic        aresetn,         // hardware reset, active low
   input  wire logic        soft_reset,      // software reset pulse
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,    // write address
   input  wire logic        s_axi_awvalid,   // write address valid
   output logic             s_axi_awready,   // write address ready
   input  wire logic [31:0] s_axi_wdata,     // write data
   input  wire logic [3:0]  s_axi_wstrb,     // write byte strobes
   input  wire logic        s_axi_wvalid,    // write data valid
   output logic             s_axi_wready,    // write data ready
   output logic [1:0]       s_axi_bresp,     // write response
   output logic             s_axi_bvalid,    // write response valid
   input  wire logic        s_axi_bready,    // write response ready
   input  wire logic [7:0]  s_axi_araddr,    // read address
   input  wire logic        s_axi_arvalid,   // read address valid
   output logic             s_axi_arready,   // read address ready
   output logic [31:0]      s_axi_rdata,     // read data
   output logic [1:0]       s_axi_rresp,     // read response
   output logic             s_axi_rvalid,    // read data valid
   input  wire logic        s_axi_rready,    // read data ready
   // receive path
   input  wire logic        carrier_sense,   // carrier sense level
   input  wire logic        rx_start,        // next frame reception begins
   input  wire logic        rx_collision,    // collision during frame
   input  wire logic        rx_end,          // frame finished, attributes valid
   input  wire logic        rx_accept,       // address filter accepted frame
   input  wire logic        rx_dst_group,    // group destination address
   input  wire logic        rx_dst_bcast,    // broadcast destination
   input  wire logic        rx_crc_bad,      // check sequence failed
   input  wire logic        rx_odd_bits,     // not on an 8-bit boundary
   input  wire logic        rx_runt,         // below minimum length
   input  wire logic        rx_from_self,    // frame was sent by us
   input  wire logic [15:0] remaining_buffer_words, // words left in area
   // outputs to the rest of the controller
   output logic [15:0]      rx_descriptor_status,   // copied status word
   output logic             desc_status_valid,      // status write strobe
   output logic [1:0]       loopback_select,        // selector bits
   output logic             lb_mac_q,        // mac loopback active
   output logic             lb_endec_q,      // endec loopback active
   output logic             lb_xcvr_q,       // transceiver loopback active
   output logic             irq              // level interrupt
);
   // register state
   logic [15:0]          rx_control_reg_q;
   logic [15:0]          rx_control_reg_d;
   logic [15:0]          buffer_end_threshold_q;
   logic [RXC_IRQ_W-1:0] irq_sts_q;
   logic [RXC_IRQ_W-1:0] irq_sts_d;
   logic [RXC_IRQ_W-1:0] irq_msk_q;
   logic [RXC_IRQ_W-1:0] irq_ev;
   logic                 col_seen_q;

   // bus state
   logic                 aw_have_q;
   logic                 w_have_q;
   logic [7:0]           aw_addr_q;
   logic [31:0]          w_data_q;
   logic [3:0]           w_strb_q;
   logic                 wr_fire;
   logic                 wr_hit;
   rxc_rd_st_t           rd_st_q;

   // frame evaluator results
   logic [15:0]          ev_flags;
   logic                 ev_acc;
   logic                 ev_err;

   // merge a 32-bit write into a 16-bit register under byte strobes
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb,
                                           input logic [15:0] wmask);
      logic [15:0] res;
      res = old;
      if (strb[0])
         res[7:0] = data[7:0];
      if (strb[1])
         res[15:8] = data[15:8];
      merge16 = (res & wmask) | (old & ~wmask);
   endfunction

   // five addresses are known to the bus decode
   function automatic logic addr_known(input logic [7:0] a);
      addr_known = (a == RXC_OFS_CTRL) || (a == RXC_OFS_IRQ_STS) ||
                   (a == RXC_OFS_IRQ_MSK) || (a == RXC_OFS_THRESH) ||
                   (a == RXC_OFS_DESC);
   endfunction

   // collision is remembered across the whole frame, since the pin
   // pulses may come long before the end strobe
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         col_seen_q <= 1'b0;
      else if (soft_reset || rx_start)
         col_seen_q <= rx_collision;
      else if (rx_collision)
         col_seen_q <= 1'b1;
   end

   rxc_frame_eval u_eval (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .frame_end  (rx_end),
      .accept     (rx_accept),
      .dst_group  (rx_dst_group),
      .dst_bcast  (rx_dst_bcast),
      .crc_bad    (rx_crc_bad),
      .odd_bits   (rx_odd_bits),
      .runt       (rx_runt),
      .collision  (col_seen_q | rx_collision),
      .from_self  (rx_from_self),
      .lb_active  (rx_control_reg_q[RXC_BIT_LB_HI:RXC_BIT_LB_LO] != RXC_LB_NORMAL),
      .words_left (remaining_buffer_words),
      .threshold  (buffer_end_threshold_q),
      .flags_q    (ev_flags),
      .done_q     (),
      .accepted_q (ev_acc),
      .error_q    (ev_err)
   );

   // write channel: address and data are taken independently,
   // the register write happens once both are held
   assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
   assign wr_hit  = wr_fire & addr_known(aw_addr_q);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q     <= 1'b0;
         aw_addr_q     <= 8'h00;
         s_axi_awready <= 1'b0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         else if (wr_fire)
            aw_have_q <= 1'b0;
         // ready drops while an address is held, so only one write runs
         s_axi_awready <= ~aw_have_q & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_have_q     <= 1'b0;
         w_data_q     <= 32'h0000_0000;
         w_strb_q     <= 4'h0;
         s_axi_wready <= 1'b0;
      end
      else
      begin
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         else if (wr_fire)
            w_have_q <= 1'b0;
         s_axi_wready <= ~w_have_q & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
      end
   end

   // write response, slverr for an unmapped address
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RXC_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? RXC_RESP_OKAY : RXC_RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // read channel: one read in flight, data registered at the address edge
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rd_st_q       <= RXC_RD_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RXC_RESP_OKAY;
      end
      else
      begin
         case (rd_st_q)
            RXC_RD_IDLE:
            begin
               s_axi_arready <= ~(s_axi_arvalid & s_axi_arready);
               if (s_axi_arvalid && s_axi_arready)
               begin
                  rd_st_q      <= RXC_RD_RESP;
                  s_axi_rvalid <= 1'b1;
                  s_axi_rresp  <= addr_known(s_axi_araddr) ? RXC_RESP_OKAY
                                                           : RXC_RESP_SLVERR;
                  case (s_axi_araddr)
                     RXC_OFS_CTRL:    s_axi_rdata <= {16'h0000, rx_control_reg_q};
                     RXC_OFS_IRQ_STS: s_axi_rdata <= {29'h0, irq_sts_q};
                     RXC_OFS_IRQ_MSK: s_axi_rdata <= {29'h0, irq_msk_q};
                     RXC_OFS_THRESH:  s_axi_rdata <= {16'h0000, buffer_end_threshold_q};
                     RXC_OFS_DESC:    s_axi_rdata <= {16'h0000, rx_descriptor_status};
                     default:         s_axi_rdata <= 32'h0000_0000;
                  endcase
               end
            end
            RXC_RD_RESP:
            begin
               s_axi_arready <= 1'b0;
               if (s_axi_rready)
               begin
                  s_axi_rvalid  <= 1'b0;
                  s_axi_arready <= 1'b1;
                  rd_st_q       <= RXC_RD_IDLE;
               end
            end
            default:
            begin
               rd_st_q       <= RXC_RD_IDLE;
               s_axi_arready <= 1'b0;
               s_axi_rvalid  <= 1'b0;
            end
         endcase
      end
   end

   // next value of the control/status register; frame start clears
   // first, so a frame end in the same cycle still sets its flags
   always_comb
   begin
      rx_control_reg_d = rx_control_reg_q;
      if (wr_hit && aw_addr_q == RXC_OFS_CTRL)
         rx_control_reg_d = merge16(rx_control_reg_q, w_data_q, w_strb_q,
                                    RXC_CTRL_WMASK);
      if (rx_start)
         rx_control_reg_d = rx_control_reg_d & ~RXC_START_CLR;
      if (ev_acc)
         rx_control_reg_d = (rx_control_reg_d & ~RXC_END_MASK) |
                            (ev_flags & RXC_END_MASK);
      rx_control_reg_d[RXC_BIT_CARR] = carrier_sense;
   end

   // soft_reset deliberately does not reach this register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rx_control_reg_q <= RXC_CTRL_RST;
      else
         rx_control_reg_q <= rx_control_reg_d;
   end

   // loopback outputs decoded from the next value so they track the register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         loopback_select <= RXC_LB_NORMAL;
         lb_mac_q        <= 1'b0;
         lb_endec_q      <= 1'b0;
         lb_xcvr_q       <= 1'b0;
      end
      else
      begin
         loopback_select <= rx_control_reg_d[RXC_BIT_LB_HI:RXC_BIT_LB_LO];
         lb_mac_q   <= rx_control_reg_d[RXC_BIT_LB_HI:RXC_BIT_LB_LO] == RXC_LB_MAC;
         lb_endec_q <= rx_control_reg_d[RXC_BIT_LB_HI:RXC_BIT_LB_LO] == RXC_LB_ENDEC;
         lb_xcvr_q  <= rx_control_reg_d[RXC_BIT_LB_HI:RXC_BIT_LB_LO] == RXC_LB_XCVR;
      end
   end

   // descriptor status copy of the whole register for accepted frames
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rx_descriptor_status <= RXC_DESC_RST;
         desc_status_valid    <= 1'b0;
      end
      else
      begin
         desc_status_valid <= ev_acc;
         if (ev_acc)
            rx_descriptor_status <= rx_control_reg_d;
      end
   end

   // end-of-buffer threshold used by the last-in-area compare
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         buffer_end_threshold_q <= RXC_THRESH_RST;
      else if (wr_hit && aw_addr_q == RXC_OFS_THRESH)
         buffer_end_threshold_q <= merge16(buffer_end_threshold_q, w_data_q,
                                           w_strb_q, 16'hffff);
   end

   // interrupt events; a new event beats a write-one-to-clear
   always_comb
   begin
      irq_ev = '0;
      irq_ev[RXC_IRQ_STORED] = ev_acc;
      irq_ev[RXC_IRQ_LAST]   = ev_acc & ev_flags[RXC_BIT_LAST];
      irq_ev[RXC_IRQ_ERR]    = ev_err;
      irq_sts_d = irq_sts_q;
      if (wr_hit && aw_addr_q == RXC_OFS_IRQ_STS && w_strb_q[0])
         irq_sts_d = irq_sts_q & ~w_data_q[RXC_IRQ_W-1:0];
      irq_sts_d = irq_sts_d | irq_ev;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_sts_q <= RXC_IRQ_RST;
         irq_msk_q <= RXC_IRQ_RST;
      end
      else
      begin
         irq_sts_q <= irq_sts_d;
         if (wr_hit && aw_addr_q == RXC_OFS_IRQ_MSK && w_strb_q[0])
            irq_msk_q <= w_data_q[RXC_IRQ_W-1:0];
      end
   end

   // interrupt level from the next status, so a new event is not a cycle late
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq <= 1'b0;
      else
         irq <= |(irq_sts_d & irq_msk_q);
   end
endmodule

// *** rtl/rxc_pkg.sv ***
package rxc_pkg;
   // register byte offsets on the axi4-lite bus
   localparam logic [7:0] RXC_OFS_CTRL    = 8'h00;
   localparam logic [7:0] RXC_OFS_IRQ_STS = 8'h04;
   localparam logic [7:0] RXC_OFS_IRQ_MSK = 8'h08;
   localparam logic [7:0] RXC_OFS_THRESH  = 8'h0c;
   localparam logic [7:0] RXC_OFS_DESC    = 8'h10;

   // rx_control_reg field positions
   localparam int RXC_BIT_LB_HI  = 10;
   localparam int RXC_BIT_LB_LO  = 9;
   localparam int RXC_BIT_GROUP  = 8;
   localparam int RXC_BIT_BCAST  = 7;
   localparam int RXC_BIT_LAST   = 6;
   localparam int RXC_BIT_CARR   = 5;
   localparam int RXC_BIT_COL    = 4;
   localparam int RXC_BIT_CRC    = 3;
   localparam int RXC_BIT_ALIGN  = 2;
   localparam int RXC_BIT_LOOP   = 1;
   localparam int RXC_BIT_GOOD   = 0;

   // reset value, software-writable bits, bits cleared at frame start
   localparam logic [15:0] RXC_CTRL_RST   = 16'h0000;
   localparam logic [15:0] RXC_CTRL_WMASK = 16'hfe00;
   localparam logic [15:0] RXC_START_CLR  = 16'h01cf;
   localparam logic [15:0] RXC_END_MASK   = 16'h01df;
   localparam logic [15:0] RXC_THRESH_RST = 16'h0000;
   localparam logic [15:0] RXC_DESC_RST   = 16'h0000;

   // loopback selector codes
   localparam logic [1:0] RXC_LB_NORMAL = 2'h0;
   localparam logic [1:0] RXC_LB_MAC    = 2'h1;
   localparam logic [1:0] RXC_LB_ENDEC  = 2'h2;
   localparam logic [1:0] RXC_LB_XCVR   = 2'h3;

   // interrupt status / mask layout
   localparam int         RXC_IRQ_W      = 3;
   localparam int         RXC_IRQ_STORED = 0;
   localparam int         RXC_IRQ_LAST   = 1;
   localparam int         RXC_IRQ_ERR    = 2;
   localparam logic [2:0] RXC_IRQ_RST    = 3'h0;

   // axi response codes
   localparam logic [1:0] RXC_RESP_OKAY   = 2'h0;
   localparam logic [1:0] RXC_RESP_SLVERR = 2'h2;

   typedef enum logic {RXC_RD_IDLE, RXC_RD_RESP} rxc_rd_st_t;
endpackage

// *** rtl/rxc_frame_eval.sv ***
`timescale 1ns/1ns
module rxc_frame_eval
   import rxc_pkg::*;
(
   input  wire logic        aclk,        // bus clock
   input  wire logic        aresetn,     // sync reset, active low
   input  wire logic        frame_end,   // frame finished
   input  wire logic        accept,      // filter accepted the frame
   input  wire logic        dst_group,   // group destination address
   input  wire logic        dst_bcast,   // all-stations destination
   input  wire logic        crc_bad,     // check sequence failed
   input  wire logic        odd_bits,    // did not end on a byte boundary
   input  wire logic        runt,        // shorter than minimum length
   input  wire logic        collision,   // collision seen during frame
   input  wire logic        from_self,   // frame sent by this station
   input  wire logic        lb_active,   // a loopback mode is selected
   input  wire logic [15:0] words_left,  // remaining_buffer_words
   input  wire logic [15:0] threshold,   // buffer_end_threshold
   output logic      [15:0] flags_q,     // status bits for the frame
   output logic             done_q,      // one-cycle result strobe
   output logic             accepted_q,  // frame was accepted
   output logic             error_q      // accepted frame had an error
);
   logic [15:0] flags_d;
   logic        align_d;
   logic        ok_d;

   // per-frame status word, evaluated from the frame attributes
   always_comb
   begin
      flags_d = 16'h0000;
      align_d = odd_bits & crc_bad;
      ok_d    = ~crc_bad & ~collision & ~runt;
      flags_d[RXC_BIT_GROUP] = dst_group;
      flags_d[RXC_BIT_BCAST] = dst_bcast;
      flags_d[RXC_BIT_LAST]  = words_left <= threshold;
      flags_d[RXC_BIT_COL]   = collision;
      // alignment wins over crc, runts never flag crc
      flags_d[RXC_BIT_CRC]   = crc_bad & ~align_d & ~runt;
      flags_d[RXC_BIT_ALIGN] = align_d;
      flags_d[RXC_BIT_LOOP]  = lb_active & from_self & ok_d;
      flags_d[RXC_BIT_GOOD]  = ok_d;
   end

   // result is held one cycle so the register merge sees a flop
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         flags_q    <= 16'h0000;
         done_q     <= 1'b0;
         accepted_q <= 1'b0;
         error_q    <= 1'b0;
      end
      else
      begin
         done_q     <= frame_end;
         accepted_q <= frame_end & accept;
         error_q    <= frame_end & accept & ~ok_d;
         if (frame_end)
            flags_q <= flags_d;
      end
   end
endmodule

// *** verif/rxc_monitor.sv ***
`timescale 1ns/1ns
module rxc_monitor
   import rxc_pkg::*;
(
   input wire logic        aclk,                 // bus clock
   input wire logic        aresetn,              // sync reset
   input wire logic        soft_reset,           // software reset
   input wire logic        rx_end,               // frame end
   input wire logic        rx_accept,            // filter verdict
   input wire logic        rx_dst_group,         // group address
   input wire logic        rx_dst_bcast,         // broadcast
   input wire logic        rx_crc_bad,           // bad fcs
   input wire logic        rx_odd_bits,          // off-byte end
   input wire logic        rx_runt,              // short frame
   input wire logic        rx_from_self,         // own frame
   input wire logic [15:0] rx_descriptor_status, // status word
   input wire logic        desc_status_valid,    // status strobe
   input wire logic [1:0]  loopback_select,      // mode
   input wire logic        lb_mac_q,             // mac loop
   input wire logic        lb_endec_q,           // endec loop
   input wire logic        lb_xcvr_q             // transceiver loop
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // status word lands two edges after an accepted frame end
   sequence s_stored;
      ##2 desc_status_valid;
   endsequence
   a_desc_timing: assert property (rx_end && rx_accept |-> s_stored)
      else $error("status word missing");
   a_desc_cause: assert property (desc_status_valid |-> $past(rx_accept, 2))
      else $error("status word for rejected frame");
   a_group_copy: assert property (desc_status_valid |->
      rx_descriptor_status[RXC_BIT_GROUP] == $past(rx_dst_group, 2))
      else $error("group flag wrong");
   a_bcast_copy: assert property (desc_status_valid |->
      rx_descriptor_status[RXC_BIT_BCAST] == $past(rx_dst_bcast, 2))
      else $error("broadcast flag wrong");
   a_crc_report: assert property (desc_status_valid |->
      rx_descriptor_status[RXC_BIT_CRC] ==
      ($past(rx_crc_bad, 2) && !$past(rx_odd_bits, 2) && !$past(rx_runt, 2)))
      else $error("crc flag wrong");
   a_align_report: assert property (desc_status_valid |->
      rx_descriptor_status[RXC_BIT_ALIGN] == ($past(rx_crc_bad, 2) && $past(rx_odd_bits, 2)))
      else $error("alignment flag wrong");
   a_good_flag: assert property (
      desc_status_valid && rx_descriptor_status[RXC_BIT_GOOD] |->
      !$past(rx_crc_bad, 2) && !$past(rx_runt, 2) && !rx_descriptor_status[RXC_BIT_COL])
      else $error("good flag on bad frame");
   a_loop_flag: assert property (desc_status_valid |->
      rx_descriptor_status[RXC_BIT_LOOP] == (rx_descriptor_status[RXC_BIT_GOOD] &&
      loopback_select != RXC_LB_NORMAL && $past(rx_from_self, 2)))
      else $error("loopback flag wrong");
   a_desc_mode: assert property (desc_status_valid |->
      rx_descriptor_status[RXC_BIT_LB_HI:RXC_BIT_LB_LO] == loopback_select)
      else $error("descriptor mode bits wrong");
   a_mode_decode: assert property (lb_mac_q == (loopback_select == RXC_LB_MAC) &&
      lb_endec_q == (loopback_select == RXC_LB_ENDEC) &&
      lb_xcvr_q == (loopback_select == RXC_LB_XCVR))
      else $error("loopback decode wrong");
   a_reset_normal: assert property ($rose(aresetn) |-> loopback_select == RXC_LB_NORMAL)
      else $error("not normal after reset");
   a_soft_keep: assert property (soft_reset |=> $stable(loopback_select))
      else $error("soft reset changed mode");
endmodule
bind rxc_top rxc_monitor rxc_monitor_i (.*);

// *** verif/rxc_medium.sv ***
`timescale 1ns/1ns
module rxc_medium (
   input  wire logic   aclk,                  // bus clock
   output logic        carrier_sense,         // carrier level
   output logic        rx_start,              // frame begins
   output logic        rx_collision,          // collision pulse
   output logic        rx_end,                // frame ends
   output logic        rx_accept,             // filter verdict
   output logic        rx_dst_group,          // group address
   output logic        rx_dst_bcast,          // broadcast
   output logic        rx_crc_bad,            // bad fcs
   output logic        rx_odd_bits,           // off-byte end
   output logic        rx_runt,               // short frame
   output logic        rx_from_self,          // own frame
   output logic [15:0] remaining_buffer_words // words left
);
   logic [6:0]  attr_q;
   logic [15:0] words_q;
   // attributes only hold with rx_end; elsewhere inverted so early sampling shows
   assign {rx_accept, rx_dst_group, rx_dst_bcast, rx_crc_bad, rx_odd_bits, rx_runt,
           rx_from_self} = rx_end ? attr_q : ~attr_q;
   assign remaining_buffer_words = rx_end ? words_q : ~words_q;
   // idle medium
   initial
   begin
      {carrier_sense, rx_start, rx_collision, rx_end} = 4'h0;
      attr_q = 7'h00;
      words_q = 16'h0000;
   end
   task automatic set_carrier(input logic v);
      @(posedge aclk);
      carrier_sense <= v;
   endtask
   // carrier comes up with the start pulse and stays until told otherwise
   task automatic start_frame();
      @(posedge aclk);
      carrier_sense <= 1'b1;
      rx_start <= 1'b1;
      @(posedge aclk);
      rx_start <= 1'b0;
   endtask
   // at: accept group bcast crc odd runt self collision
   task automatic end_frame(input logic [7:0] at, input logic [15:0] w);
      @(posedge aclk);
      rx_collision <= at[0];
      @(posedge aclk);
      rx_collision <= 1'b0;
      @(posedge aclk);
      rx_end <= 1'b1;
      attr_q <= at[7:1];
      words_q <= w;
      @(posedge aclk);
      rx_end <= 1'b0;
   endtask
endmodule

// *** verif/test_rx_loopback_and_status_bits.sv ***
`timescale 1ns/1ns
module test_rx_loopback_and_status_bits
   import rxc_pkg::*;
();
   localparam logic [15:0] THR = 16'h0010;
   logic        aclk = 1'b0, aresetn = 1'b0, soft_reset = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, loopback_select, r, lb;
   logic        carrier_sense, rx_start, rx_collision, rx_end, rx_accept, rx_dst_group;
   logic        rx_dst_bcast, rx_crc_bad, rx_odd_bits, rx_runt, rx_from_self, seen;
   logic        desc_status_valid, lb_mac_q, lb_endec_q, lb_xcvr_q, irq;
   logic [15:0] remaining_buffer_words, rx_descriptor_status, st, w;
   logic [31:0] d;
   logic [7:0]  at;
   int          n_errors = 0, cmp_count = 0;
   // lb, attributes (accept group bcast crc odd runt self col), words left
   logic [25:0] rows [7] = '{{2'h0, 8'hc0, 16'h0100}, {2'h1, 8'ha2, 16'h0010},
      {2'h2, 8'h98, 16'h0011}, {2'h3, 8'h96, 16'h000f}, {2'h0, 8'h90, 16'h0200},
      {2'h0, 8'hc1, 16'h0005}, {2'h0, 8'h40, 16'h0005}};
   rxc_top rxc_top_i (.*);
   rxc_medium rxc_medium_i (.*);
   // free-running bus clock
   always #20 aclk = ~aclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d checks %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] dt, output logic [1:0] rs);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= dt;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      fork
         begin
            do @(posedge aclk); while (s_axi_awready !== 1'b1);
            s_axi_awvalid <= 1'b0;
         end
         begin
            do @(posedge aclk); while (s_axi_wready !== 1'b1);
            s_axi_wvalid <= 1'b0;
         end
      join
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rs);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      {dt, rs} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
   endtask
   // expected status word; carrier stays up through the frame, so bit 5 is set
   function automatic logic [15:0] exp_st(input logic [25:0] row);
      logic [1:0] l;
      logic [7:0] a;
      logic [15:0] n;
      logic good;
      {l, a, n} = row;
      good = !a[4] && !a[2] && !a[0];
      return {5'h00, l, a[6], a[5], n <= THR, 1'b1, a[0], a[4] && !a[3] && !a[2],
              a[4] && a[3], good && l != RXC_LB_NORMAL && a[1], good};
   endfunction
   // watchdog well beyond the expected run length
   initial
   begin
      #(40 * 4000);
      n_errors++;
      finish_test();
   end
   // main sequence
   initial
   begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd(RXC_OFS_CTRL, d, r);
      chk(d, 32'h0);
      wr(RXC_OFS_THRESH, 32'(THR), r);
      chk(32'(r), 32'(RXC_RESP_OKAY));
      for (int i = 0; i < 7; i++)
      begin
         {lb, at, w} = rows[i];
         wr(RXC_OFS_CTRL, {21'h0, lb, 9'h0}, r);
         @(posedge aclk);
         #1 chk(32'({lb_xcvr_q, lb_endec_q, lb_mac_q, loopback_select}),
                32'({lb == 2'h3, lb == 2'h2, lb == 2'h1, lb}));
         rxc_medium_i.start_frame();
         rxc_medium_i.end_frame(at, w);
         {seen, st} = 17'h0;
         repeat (4)
         begin
            @(posedge aclk);
            #1 if (desc_status_valid === 1'b1) {seen, st} = {1'b1, rx_descriptor_status};
         end
         chk(32'(seen), 32'(at[7]));
         chk(32'(st), at[7] ? 32'(exp_st(rows[i]))
             : 32'h0);
         rd(RXC_OFS_CTRL, d, r);
         chk(d, at[7] ? 32'(exp_st(rows[i])) : 32'h0030);
      end
      rxc_medium_i.set_carrier(1'b0);
      repeat (3) @(posedge aclk);
      rd(RXC_OFS_CTRL, d, r);
      chk(d, 32'h0010);
      wr(RXC_OFS_CTRL, 32'hffffffff, r);
      @(posedge aclk) soft_reset <= 1'b1;
      @(posedge aclk) soft_reset <= 1'b0;
      rd(RXC_OFS_CTRL, d, r);
      chk(d, 32'hfe10);
      rd(RXC_OFS_IRQ_STS, d, r);
      chk(d, 32'h7);
      #1 chk(32'(irq), 32'h0);
      wr(RXC_OFS_IRQ_MSK, 32'h2, r);
      repeat (2) @(posedge aclk);
      #1 chk(32'(irq), 32'h1);
      wr(RXC_OFS_IRQ_STS, 32'h7, r);
      repeat (2) @(posedge aclk);
      #1 chk(32'(irq), 32'h0);
      rd(8'h20, d, r);
      chk({d[29:0], r}, 32'(RXC_RESP_SLVERR));
      wr(8'h20, 32'h1, r);
      chk(32'(r), 32'(RXC_RESP_SLVERR));
      @(posedge aclk) aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(RXC_OFS_CTRL, d, r);
      #1 chk({d[29:0], loopback_select}, 32'h0);
      finish_test();
   end
endmodule
